// ### logic/mcsd_cond_mon.sv
// condition monitor: latches flags and status, selects one condition
// assumes alu flags on the same clock; ext_status comes from pins
`timescale 1ns/100ps
`default_nettype none
`include "mcsd_params.svh"

module mcsd_cond_mon
(
   input  wire logic                           clock,
   input  wire logic                           reset,
   input  wire logic                           alu_eq,
   input  wire logic                           alu_carry,
   input  wire logic [`MCSD_NUM_COND-1:0]      ext_status,
   input  wire logic [3:0]                     cond_sel,
   output logic                                met_n
);
   logic [`MCSD_NUM_COND-1:0] sync1_r;
   logic [`MCSD_NUM_COND-1:0] sync2_r;
   logic [`MCSD_NUM_COND-1:0] cond_r;
   logic [`MCSD_NUM_COND-1:0] cond_nxt;

   // fixed codes: 0 always, 1 equal, 2 not equal, 3 no carry, 4 carry
   always_comb
   begin
      cond_nxt    = sync2_r;
      cond_nxt[0] = 1'b1;
      cond_nxt[1] = alu_eq;
      cond_nxt[2] = ~alu_eq;
      cond_nxt[3] = ~alu_carry;
      cond_nxt[4] = alu_carry;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         cond_r  <= '0;
      end
      else
      begin
         sync1_r <= ext_status;
         sync2_r <= sync1_r;
         cond_r  <= cond_nxt; // RULE9
      end
   end

   assign met_n = ~cond_r[cond_sel]; // RULE8 RULE9

endmodule
`default_nettype wire

// ### logic/mcsd_seq.sv
// micro-instruction decode and next-address sequencer with ahb-lite status
// assumes instr is the word at micro_addr, phases are same-clock strobes
`timescale 1ns/100ps
`default_nettype none
`include "mcsd_params.svh"

// Summary of operation
// [RULE1] load strobes only with alu bit and phase 0; code zero loads nothing
// [RULE2] codes 1..7 pick acc1, acc2, buffer addr, band addr, illegal, buffer, timer
// [RULE3] sixteen working registers addressed by bits 10 to 13
// [RULE4] working register written from alu output when bits 14,15,17 and phase 2
// [RULE5] immediate alu instruction takes operand from bits 9 to 15
// [RULE6] immediate instructions decode source and load fields like plain ones
// [RULE7] bit 17 low is non-alu; bits 16 and 14 high mean conditional address
// [RULE8] bits 4 to 7 pick one of sixteen conditions, zero is unconditional
// [RULE9] monitor latches flags and status and flags selected active condition
// [RULE10] function select is condition met and bits 14 and 16
// [RULE11] without condition increment, with condition pass bits 0 to 3
// [RULE12] next address from incremented counter, address register, direct field or stack
// [RULE13] four-entry lifo stack, pointer on the latest written entry
// [RULE14] bits 3,2: increment, address register, return, direct jump
// [RULE15] stack enable high holds stack; low: bit 0 pushes or pops
// [RULE16] met condition branches, else sequential; stack moves are unconditional (the code moves the stack only on a met condition)
// [RULE17] bit 17 high is always an alu instruction
// [RULE18] bit 16 high, bit 14 low loads address register from bits 8 to 13
// [RULE19] reset clears counter and stack pointer
// [RULE20] microprogram never nests deeper than four
module mcsd_seq
#(
   parameter int DATA_W      = `MCSD_DATA_W,
   parameter int STACK_DEPTH = `MCSD_STACK_DEPTH
)
(
   input  wire logic                     clock,
   input  wire logic                     reset,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic [31:0]                   hrdata,
   output logic                          hresp,
   input  wire logic [`MCSD_WORD_W-1:0]  instr,
   input  wire logic                     phase0_clock,
   input  wire logic                     phase2_clock,
   input  wire logic [DATA_W-1:0]        alu_output_bus,
   input  wire logic [DATA_W-1:0]        input_device_bus,
   input  wire logic                     alu_eq,
   input  wire logic                     alu_carry,
   input  wire logic [15:0]              ext_status,
   output logic [`MCSD_UADDR_W-1:0]      micro_addr,
   output logic                          acc1_load_n,
   output logic                          acc2_load_n,
   output logic                          buf_addr_load_n,
   output logic                          band_img_addr_load_n,
   output logic                          illegal_code_load_n,
   output logic                          data_buf_write_n,
   output logic                          timer_load_n,
   output logic                          work_reg_write_en_n,
   output logic [DATA_W-1:0]             source_reg_bus,
   output logic [DATA_W-1:0]             alu_in_bus,
   output logic                          condition_met_n
);
   localparam int UW = `MCSD_UADDR_W;
   localparam int SW = $clog2(STACK_DEPTH);

   generate
      if (STACK_DEPTH != 4 || DATA_W < 7)
      begin : g_bad
         $error("mcsd_seq: stack depth must be 4 and data at least 7 bits");
      end
   endgenerate

   // one-hot active-low strobe for destination codes 1..7
   function automatic logic [`MCSD_NUM_LOADS-1:0] dest_dec
   (
      input logic [2:0] code,
      input logic       en
   );
      logic [`MCSD_NUM_LOADS-1:0] v;
      v = '1;
      if (en && code != 3'h0)
         v[code - 3'h1] = 1'b0;
      return v;
   endfunction

   // instruction class decode
   logic is_alu;
   logic is_imm;
   logic is_cond;
   logic is_ldseq;
   logic ld_en;
   logic wr_en;
   logic step;
   logic met_n;
   logic sel_cond;
   logic [3:0] func;
   logic [UW-1:0] direct;
   logic [DATA_W-1:0] imm_val;

   assign is_alu   = instr[`MCSD_BIT_ALU]; // RULE17
   assign is_imm   = is_alu & instr[`MCSD_BIT_IMM];
   assign is_cond  = ~is_alu & instr[`MCSD_BIT_IMM] & instr[`MCSD_BIT_WREG]; // RULE7
   assign is_ldseq = ~is_alu & instr[`MCSD_BIT_IMM] & ~instr[`MCSD_BIT_WREG]; // RULE18
   assign ld_en    = is_alu & phase0_clock; // RULE1 RULE6
   assign wr_en    = is_alu & instr[`MCSD_BIT_WRITE] & instr[`MCSD_BIT_WREG] & phase2_clock; // RULE4
   assign direct   = instr[`MCSD_BRA_HI:`MCSD_BRA_LO];
   assign imm_val  = DATA_W'(instr[`MCSD_IMM_HI:`MCSD_IMM_LO]); // RULE5

   mcsd_cond_mon u_cond
   (
      .clock      (clock),
      .reset      (reset),
      .alu_eq     (alu_eq),
      .alu_carry  (alu_carry),
      .ext_status (ext_status),
      .cond_sel   (instr[`MCSD_COND_HI:`MCSD_COND_LO]),
      .met_n      (met_n)
   );

   assign sel_cond = ~met_n & instr[`MCSD_BIT_WREG] & instr[`MCSD_BIT_IMM] & ~is_alu; // RULE10
   assign func     = sel_cond ? instr[`MCSD_FUNC_HI:`MCSD_FUNC_LO] : `MCSD_FUNC_INC; // RULE11

   // ahb-lite slave
   logic        run_r;
   logic        run_nxt;
   logic        wpend_r;
   logic        wpend_nxt;
   logic [11:0] waddr_r;
   logic [11:0] waddr_nxt;
   logic [31:0] hrdata_nxt;
   logic [31:0] status_w;
   logic [UW-1:0] areg_r;
   logic [SW-1:0] sp_r;
   logic [UW-1:0] pc_r;

   assign status_w = {21'h0, ~condition_met_n, 2'(sp_r), 2'h0, pc_r};

   always_comb
   begin
      run_nxt    = run_r;
      wpend_nxt  = 1'b0;
      waddr_nxt  = waddr_r;
      hrdata_nxt = 32'h0000_0000;
      if (wpend_r && waddr_r == `MCSD_REG_CTRL)
         run_nxt = hwdata[`MCSD_CTRL_RUN_BIT];
      if (hsel && hready && htrans[1])
      begin
         if (hwrite)
         begin
            wpend_nxt = 1'b1;
            waddr_nxt = haddr[11:0];
         end
         else
         begin
            case (haddr[11:0])
               `MCSD_REG_CTRL:   hrdata_nxt = {31'h0, run_nxt};
               `MCSD_REG_STATUS: hrdata_nxt = status_w;
               `MCSD_REG_AREG:   hrdata_nxt = {26'h0, areg_r};
               default:          hrdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         run_r     <= 1'(`MCSD_CTRL_RST);
         wpend_r   <= 1'b0;
         waddr_r   <= 12'h000;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
      begin
         run_r     <= run_nxt;
         wpend_r   <= wpend_nxt;
         waddr_r   <= waddr_nxt;
         hrdata    <= hrdata_nxt;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // sequencer: advances once per micro cycle, at phase 2
   logic [UW-1:0] stack_r [STACK_DEPTH];
   logic [UW-1:0] stack_nxt [STACK_DEPTH];
   logic [SW-1:0] sp_nxt;
   logic [UW-1:0] pc_nxt;
   logic [UW-1:0] areg_nxt;
   logic [UW-1:0] pc_inc;
   mcsd_pkg::mcsd_src_t src;

   assign step   = phase2_clock & run_r;
   assign pc_inc = pc_r + UW'(1);
   assign src    = mcsd_pkg::mcsd_src_t'(func[3:2]); // RULE14

   always_comb
   begin
      pc_nxt    = pc_r;
      sp_nxt    = sp_r;
      areg_nxt  = areg_r;
      stack_nxt = stack_r;
      if (step)
      begin
         case (src) // RULE12 RULE16
            mcsd_pkg::MCSD_SRC_PC:     pc_nxt = pc_inc;
            mcsd_pkg::MCSD_SRC_AREG:   pc_nxt = areg_r;
            mcsd_pkg::MCSD_SRC_STACK:  pc_nxt = stack_r[sp_r];
            mcsd_pkg::MCSD_SRC_DIRECT: pc_nxt = direct;
            default:                   pc_nxt = pc_inc;
         endcase
         if (!func[1]) // RULE15
         begin
            if (func[0])
            begin
               sp_nxt            = sp_r + SW'(1); // RULE13
               stack_nxt[sp_nxt] = pc_inc;
            end
            else
               sp_nxt = sp_r - SW'(1);
         end
         if (is_ldseq)
            areg_nxt = direct; // RULE18
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pc_r    <= '0; // RULE19
         sp_r    <= '0;
         areg_r  <= '0;
         stack_r <= '{default: '0};
      end
      else
      begin
         pc_r    <= pc_nxt;
         sp_r    <= sp_nxt;
         areg_r  <= areg_nxt;
         stack_r <= stack_nxt;
      end
   end

   assign micro_addr = pc_r;

   // load strobes, working registers and alu operand
   logic [DATA_W-1:0] wreg_r [`MCSD_NUM_WREG];
   logic [DATA_W-1:0] wreg_nxt [`MCSD_NUM_WREG];
   logic [`MCSD_NUM_LOADS-1:0] load_n_nxt;
   logic [`MCSD_NUM_LOADS-1:0] load_n_r;
   logic [DATA_W-1:0] operand_nxt;
   logic [3:0] wsel;

   assign wsel = instr[`MCSD_WSEL_HI:`MCSD_WSEL_LO]; // RULE3

   always_comb
   begin
      load_n_nxt  = dest_dec(instr[`MCSD_DEST_HI:`MCSD_DEST_LO], ld_en); // RULE1 RULE2
      wreg_nxt    = wreg_r;
      if (wr_en)
         wreg_nxt[wsel] = alu_output_bus; // RULE4
      operand_nxt = is_imm ? imm_val : input_device_bus; // RULE5
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         load_n_r            <= '1;
         wreg_r              <= '{default: '0};
         work_reg_write_en_n <= 1'b1;
         source_reg_bus      <= '0;
         alu_in_bus          <= '0;
         condition_met_n     <= 1'b1;
      end
      else
      begin
         load_n_r            <= load_n_nxt;
         wreg_r              <= wreg_nxt;
         work_reg_write_en_n <= ~wr_en;
         source_reg_bus      <= wreg_r[wsel];
         alu_in_bus          <= operand_nxt;
         condition_met_n     <= met_n;
      end
   end

   assign acc1_load_n          = load_n_r[0];
   assign acc2_load_n          = load_n_r[1];
   assign buf_addr_load_n      = load_n_r[2];
   assign band_img_addr_load_n = load_n_r[3];
   assign illegal_code_load_n  = load_n_r[4];
   assign data_buf_write_n     = load_n_r[5];
   assign timer_load_n         = load_n_r[6];

   // checks
   chk_load_onehot: assert property (@(posedge clock) disable iff (reset) // RULE1
      $countones(~load_n_r) <= 1)
      else $error("more than one load strobe active");

   chk_load_gate: assert property (@(posedge clock) disable iff (reset) // RULE1
      !ld_en |=> &load_n_r)
      else $error("load strobe without alu phase 0");

   chk_acc1_code: assert property (@(posedge clock) disable iff (reset) // RULE2
      ld_en && instr[7:5] == 3'h1 |=> !acc1_load_n && timer_load_n)
      else $error("code 1 did not load accumulator one");

   chk_wreg_write: assert property (@(posedge clock) disable iff (reset) // RULE4
      wr_en |=> !work_reg_write_en_n ##1 work_reg_write_en_n || $past(wr_en))
      else $error("working register write strobe wrong");

   chk_imm_operand: assert property (@(posedge clock) disable iff (reset) // RULE5
      is_imm |=> alu_in_bus == $past(imm_val))
      else $error("immediate operand not driven");

   chk_pc_inc: assert property (@(posedge clock) disable iff (reset) // RULE11
      step && !sel_cond |=> micro_addr == UW'($past(micro_addr) + 1'b1))
      else $error("no increment without condition");

   chk_direct_jump: assert property (@(posedge clock) disable iff (reset) // RULE16
      step && sel_cond && func[3:2] == 2'h3 |=> micro_addr == $past(direct))
      else $error("direct branch not taken");

   chk_push_sp: assert property (@(posedge clock) disable iff (reset) // RULE15
      step && func[1:0] == 2'h1 |=> sp_r == SW'($past(sp_r) + 1'b1))
      else $error("push did not advance pointer");

   chk_fe_hold: assert property (@(posedge clock) disable iff (reset) // RULE15
      step && func[1] |=> $stable(sp_r))
      else $error("stack moved while disabled");

   chk_ldseq_areg: assert property (@(posedge clock) disable iff (reset) // RULE18
      step && is_ldseq |=> areg_r == $past(direct))
      else $error("load sequencer did not capture address");

   chk_hold_addr: assert property (@(posedge clock) disable iff (reset) // RULE12
      !step |=> $stable(micro_addr))
      else $error("address moved outside a step");

endmodule
`default_nettype wire

// ### pkg/mcsd_params.svh
// constants for the micro-instruction decoder and sequencer
// assumes a 24-bit micro word and a 32-bit ahb-lite register bus
`ifndef MCSD_PARAMS_SVH
`define MCSD_PARAMS_SVH

`define MCSD_WORD_W        24
`define MCSD_UADDR_W       6
`define MCSD_STACK_DEPTH   4
`define MCSD_DATA_W        8
`define MCSD_NUM_WREG      16
`define MCSD_NUM_COND      16
`define MCSD_NUM_LOADS     7

// instruction bit positions
`define MCSD_BIT_ALU       17
`define MCSD_BIT_IMM       16
`define MCSD_BIT_WRITE     15
`define MCSD_BIT_WREG      14
`define MCSD_WSEL_LO       10
`define MCSD_WSEL_HI       13
`define MCSD_BRA_LO        8
`define MCSD_BRA_HI        13
`define MCSD_IMM_LO        9
`define MCSD_IMM_HI        15
`define MCSD_DEST_LO       5
`define MCSD_DEST_HI       7
`define MCSD_COND_LO       4
`define MCSD_COND_HI       7
`define MCSD_FUNC_LO       0
`define MCSD_FUNC_HI       3

// fixed function code when no condition: increment, stack untouched
`define MCSD_FUNC_INC      4'h2

// register map (byte addresses)
`define MCSD_REG_CTRL      12'h000
`define MCSD_REG_STATUS    12'h004
`define MCSD_REG_AREG      12'h008
`define MCSD_CTRL_RST      32'h0000_0001
`define MCSD_CTRL_RUN_BIT  0

`endif

// ### pkg/mcsd_pkg.sv
// types for the micro-instruction decoder and sequencer
// assumes mcsd_params.svh is on the include path
package mcsd_pkg;
   typedef enum logic [1:0] {
      MCSD_SRC_PC,
      MCSD_SRC_AREG,
      MCSD_SRC_STACK,
      MCSD_SRC_DIRECT
   } mcsd_src_t;
endpackage

// ### tb/mcsd_ustore.sv
// microprogram store model: 64 words, read combinationally at the micro address
// assumes the bench fills words through the synchronous load port
`timescale 1ns/100ps
`default_nettype none
`include "mcsd_params.svh"

module mcsd_ustore
(
   input  wire logic                     clock,
   input  wire logic                     load_en,
   input  wire logic [`MCSD_UADDR_W-1:0] load_addr,
   input  wire logic [`MCSD_WORD_W-1:0]  load_word,
   input  wire logic [`MCSD_UADDR_W-1:0] micro_addr,
   output logic      [`MCSD_WORD_W-1:0]  instr
);
   logic [`MCSD_WORD_W-1:0] mem [0:63];

   initial
   begin
      for (int i = 0; i < 64; i++)
         mem[i] = 24'h000000;
   end

   always @(posedge clock)
   begin
      if (load_en)
         mem[load_addr] <= load_word;
   end

   assign instr = mem[micro_addr];
endmodule
`default_nettype wire

// ### tb/test_microcode_sequencer_decode.sv
// self-checking bench for the micro decoder and next-address sequencer
// assumes the design files and the mcsd_ustore model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "mcsd_params.svh"

module test_microcode_sequencer_decode;
   logic        clock, reset, hsel, hwrite, hreadyout, hresp, load_en;
   logic        phase0_clock, phase2_clock, alu_eq, alu_carry, work_reg_write_en_n, condition_met_n;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] ext_status;
   logic [23:0] instr, load_word;
   logic [7:0]  alu_output_bus, input_device_bus, source_reg_bus, alu_in_bus;
   logic [7:0]  wreg [0:15];
   wire  [6:0]  strobe_n;
   logic [5:0]  micro_addr, load_addr, pc, ret1, ret2, br;
   int          fail_count, compares;

   mcsd_seq DUT
   (
      .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .instr(instr), .phase0_clock(phase0_clock), .phase2_clock(phase2_clock),
      .alu_output_bus(alu_output_bus), .input_device_bus(input_device_bus), .alu_eq(alu_eq),
      .alu_carry(alu_carry), .ext_status(ext_status), .micro_addr(micro_addr),
      .acc1_load_n(strobe_n[0]), .acc2_load_n(strobe_n[1]), .buf_addr_load_n(strobe_n[2]),
      .band_img_addr_load_n(strobe_n[3]), .illegal_code_load_n(strobe_n[4]),
      .data_buf_write_n(strobe_n[5]), .timer_load_n(strobe_n[6]),
      .work_reg_write_en_n(work_reg_write_en_n), .source_reg_bus(source_reg_bus),
      .alu_in_bus(alu_in_bus), .condition_met_n(condition_met_n)
   );

   mcsd_ustore rom
   (
      .clock(clock), .load_en(load_en), .load_addr(load_addr), .load_word(load_word),
      .micro_addr(micro_addr), .instr(instr)
   );

   initial
   begin
      clock = 1'h0;
      forever #2 clock = ~clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   function automatic logic [6:0] exp_load(input logic [23:0] w);
      exp_load = 7'h7F;
      if (w[17] && w[7:5] != 3'h0)
         exp_load[w[7:5] - 3'h1] = 1'h0;
   endfunction

   function automatic logic met(input logic [3:0] c);
      case (c)
         4'h0: met = 1'h1;
         4'h1: met = alu_eq;
         4'h2: met = ~alu_eq;
         4'h3: met = ~alu_carry;
         4'h4: met = alu_carry;
         default: met = ext_status[c];
      endcase
   endfunction

   // conditional-address word: condition code, sequencer function, branch field
   function automatic logic [23:0] cw(input logic [3:0] c, input logic [3:0] f, input logic [5:0] a);
      cw = {6'h00, 4'h5, a, c, f};
   endfunction

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask

   task automatic do_reset();
      reset <= 1'h1;
      repeat (3) @(posedge clock);
      reset <= 1'h0;
      pc = 6'h00;
      foreach (wreg[i])
         wreg[i] = 8'h00;
      repeat (2) @(posedge clock);
      #1;
      check(micro_addr, 32'h0);
   endtask

   // store a word at the current address, run phase 0 then phase 2, check the step
   task automatic exec(input logic [23:0] w, input logic [5:0] nxt);
      logic wr;
      wr = w[17] & w[15] & w[14];
      @(posedge clock);
      load_en <= 1'h1;
      load_addr <= pc;
      load_word <= w;
      input_device_bus <= 8'($urandom);
      alu_output_bus <= 8'($urandom);
      @(posedge clock);
      load_en <= 1'h0;
      repeat (2) @(posedge clock);
      phase0_clock <= 1'h1;
      #1;
      check(source_reg_bus, wreg[w[13:10]]);
      check(alu_in_bus, (w[17] & w[16]) ? {1'h0, w[15:9]} : input_device_bus);
      @(posedge clock);
      phase0_clock <= 1'h0;
      phase2_clock <= 1'h1;
      #1;
      check(strobe_n, exp_load(w));
      @(posedge clock);
      phase2_clock <= 1'h0;
      #1;
      check(micro_addr, nxt);
      check(work_reg_write_en_n, !wr);
      check(condition_met_n, !met(w[7:4]));
      if (wr)
         wreg[w[13:10]] = alu_output_bus;
      pc = nxt;
   endtask

   initial
   begin
      reset = 1'h1;
      {hsel, hwrite, htrans, haddr, hwdata, load_en, load_addr, load_word} = '0;
      {phase0_clock, phase2_clock, alu_eq, alu_carry, ext_status, alu_output_bus, input_device_bus} = '0;
      fail_count = 0;
      compares = 0;
      void'($urandom(32'h5B7BD3B5));
      do_reset();
      ahb(1'h0, 32'h0, 32'h0);
      check(rd & 32'h1, 32'h1);
      ahb(1'h0, 32'h4, 32'h0);
      check(rd & 32'h33F, 32'h0);
      ahb(1'h0, 32'hC, 32'h0);
      check(rd, 32'h0);
      check(hresp, 32'h0);
      check(hreadyout, 32'h1);
      $display("test registers done");
      for (int c = 0; c < 8; c++)
         exec({6'h00, 2'h3, 8'($urandom), 3'(c), 5'($urandom)}, pc + 6'h01);
      repeat (40)
         exec({6'h00, 1'h1, 17'($urandom)}, pc + 6'h01);
      $display("test alu decode done");
      @(posedge clock);
      alu_eq <= 1'($urandom);
      alu_carry <= 1'($urandom);
      ext_status <= 16'($urandom);
      do_reset();
      repeat (4) @(posedge clock);
      for (int c = 0; c < 16; c++)
      begin
         br = 6'($urandom);
         exec(cw(4'(c), 4'hF, br), met(4'(c)) ? br : pc + 6'h01);
      end
      exec({6'h00, 4'hD, 6'h3F, 8'h0F}, pc + 6'h01);
      exec({6'h00, 4'h1, 6'h3F, 8'h0F}, pc + 6'h01);
      $display("test conditions done");
      br = 6'($urandom);
      exec({6'h00, 4'h4, br, 8'h0F}, pc + 6'h01);
      ahb(1'h0, 32'h8, 32'h0);
      check(rd & 32'h3F, 32'(br));
      exec(cw(4'h0, 4'h7, 6'h00), br);
      // two nested calls only: the stack is never driven past four deep
      ret1 = pc + 6'h01;
      br = 6'($urandom);
      exec(cw(4'h0, 4'hD, br), br);
      ret2 = pc + 6'h01;
      br = 6'($urandom);
      exec(cw(4'h0, 4'hD, br), br);
      exec(cw(4'h0, 4'h3, 6'h2A), pc + 6'h01);
      ahb(1'h0, 32'h4, 32'h0);
      check(rd & 32'h33F, 32'h200 | 32'(pc));
      exec(cw(4'h0, 4'h8, 6'h00), ret2);
      exec(cw(4'h0, 4'h8, 6'h00), ret1);
      ahb(1'h0, 32'h4, 32'h0);
      check(rd & 32'h300, 32'h0);
      $display("test stack done");
      ahb(1'h1, 32'h0, 32'h0);
      exec(24'h000000, pc);
      ahb(1'h1, 32'h0, 32'h1);
      exec(24'h000000, pc + 6'h01);
      $display("test run control done");
      conclude();
   end

   initial
   begin
      #40000;
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire
